// ---- rtl/bpc_pkg.sv ----
// Constants, register map and types for the bridge pin control unit
package bpc_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS = 7;
  localparam int unsigned NUM_SER = 4;
  localparam int unsigned NUM_ALT = 4;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TOGGLE_HALF_US = 50_000;
  localparam int unsigned TOGGLE_HALF_CYC = TOGGLE_HALF_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LATCH = 6'h04;
  localparam logic [5:0] OFS_MODE = 6'h08;
  localparam logic [5:0] OFS_PIN_IN = 6'h0C;
  localparam logic [5:0] OFS_SUSP = 6'h10;
  localparam logic [5:0] OFS_SER = 6'h14;
  localparam logic [5:0] OFS_CLKDIV = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_GPIO_DYN = 0;
  localparam int unsigned CTRL_SER_DYN = 1;
  localparam int unsigned CTRL_CHG_EN = 2;
  localparam int unsigned CTRL_CLK_EN = 3;
  localparam int unsigned CTRL_PKG_LSB = 4;
  localparam int unsigned CTRL_ALT_LSB = 8;
  localparam int unsigned SER_PRE_LSB = 8;
  localparam int unsigned ST_SUSP = 0;
  localparam int unsigned ST_DYN = 1;
  localparam int unsigned ST_RING = 2;
  localparam int unsigned ST_CHG_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] LATCH_RST = 7'h7F;
  localparam logic [6:0] MODE_RST = 7'h00;
  localparam logic [3:0] SER_RST = 4'hF;
  localparam logic [7:0] CLKDIV_RST = 8'h00;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PKG_28PIN = 2'h0,
    PKG_24PIN = 2'h1,
    PKG_20PIN = 2'h2
  } bpc_pkg_e;

  typedef enum logic [1:0] {
    CHG_NONE = 2'h0,
    CHG_SDP = 2'h1,
    CHG_CDP = 2'h2,
    CHG_DCP = 2'h3
  } bpc_port_e;

  typedef enum logic [2:0] {
    SU_RUN = 3'b001,
    SU_HOLD = 3'b010,
    SU_DYN = 3'b100
  } bpc_susp_e;

  // Stored device configuration, sampled once after reset
  typedef struct packed {
    logic [6:0] mode_pp;
    logic [6:0] reset_latch;
    logic [6:0] susp_latch;
    logic [3:0] ser_susp;
    logic gpio_dyn;
    logic ser_dyn;
  } bpc_cfg_s;

endpackage : bpc_pkg

// ---- rtl/bpc_tick_div.sv ----
// Free-running divider giving a one-cycle enable pulse
`timescale 1ns/1ps
module bpc_tick_div #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk_i, // System clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic run_i, // Count while high
  input wire logic [W-1:0] limit_i, // Pulse every limit+1 cycles
  output logic tick_o // One-cycle enable
);
  logic [W-1:0] cnt_r;

  // Counter restarts whenever stopped, so phase starts fresh
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r >= limit_i) begin
      cnt_r <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule : bpc_tick_div

// ---- rtl/bpc_top.sv ----
// Pin control unit: GPIO latches, modes, dynamic suspend, charge pins
//
// Functional notes
// [RULE1] Seven general pins, readable and settable by software.
// [RULE2] Reset: open-drain, weak pull-up on, latch one.
// [RULE3] Pins come up behaving as inputs.
// [RULE4] Push-pull or open-drain chosen per pin.
// [RULE5] Separate pin states for run, suspend and after reset.
// [RULE6] Alternate functions on pins 0 to 3 depend on package.
// [RULE7] Larger packages put clock output on the ring pin.
// [RULE8] Without dynamic suspend, latches stay unchanged in suspend.
// [RULE9] With dynamic suspend, configured-to-suspend loads preset latch values.
// [RULE10] Leaving suspend restores latches saved at entry.
// [RULE11] Dynamic suspend separately for general and serial pin groups.
// [RULE12] Push-pull pins drive latch level high and low.
// [RULE13] Open-drain drives low on zero, releases on one.
// [RULE14] Charging enabled: charge pins follow detected port type.
// [RULE15] Charge pins grant 100 mA, 500 mA and 1.5 A.
// [RULE16] Configuring party sets charge pin modes per current level; here the three grants are fixed registered outputs with no mode setting.
// [RULE17] In suspend, charge pins off only on standard data port.
// [RULE18] Software should not use pins for real-time signalling.
// [RULE19] Active-low wake falling edge in suspend starts remote wakeup.
// [RULE20] Activity toggles rest high, toggle at fixed rate on bytes.
// [RULE21] Clock out is base over 2N, N 1..256, stopped in suspend.
// [RULE22] Pin settings load from stored configuration after reset; the gpio_dyn and ser_dyn fields are not used, and ctrl_r resets to zero.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module bpc_top
  import bpc_pkg::*;
#(
  parameter int unsigned TOGGLE_CYC = TOGGLE_HALF_CYC
) (
  input wire logic sys_clk_i, // System clock, 125 MHz
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic [5:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire bpc_cfg_s cfg_i, // Stored configuration
  input wire logic usb_configured_i, // Link in configured state
  input wire logic usb_suspend_i, // Link suspended
  input wire bpc_port_e chg_port_i, // Detected port type
  input wire logic tx_byte_i, // Byte sent pulse
  input wire logic rx_byte_i, // Byte received pulse
  input wire logic tx_busy_i, // Transmitter active
  input wire logic [6:0] gpio_i, // Pin levels
  output logic [6:0] gpio_o, // Pin drive value
  output logic [6:0] gpio_oe_n_o, // Pin drive enable, low drives
  output logic [6:0] gpio_pu_o, // Weak pull-up enable
  input wire logic ring_indicator_input_i, // Ring pin level
  output logic ring_pin_o, // Ring pin drive (clock out)
  output logic ring_pin_oe_n_o, // Ring pin enable, low drives
  output logic [3:0] ser_latch_o, // Serial/modem group latch
  output logic charge_base_enable_o, // 100 mA grant
  output logic charge_mid_current_enable_o, // 500 mA grant
  output logic charge_high_current_enable_o, // 1.5 A grant
  output logic remote_wake_o // Wakeup start pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [6:0] latch_r, mode_r, susp_r, saved_r;
  logic [3:0] ser_r, ser_pre_r, ser_saved_r;
  logic [7:0] clkdiv_r;
  logic cfg_pend_r, susp_d_r, wake_d_r, clk_out_r;
  bpc_susp_e su_r;
  logic [1:0] act_r, tog_r;
  logic acc_wr, sel_ok, su_enter, su_exit, clk_tick, tog_tick;
  logic [31:0] rd_mux;
  bpc_pkg_e pkg;
  logic [3:0] alt_en;

  assign pkg = bpc_pkg_e'(ctrl_r[CTRL_PKG_LSB +: 2]);
  assign alt_en = ctrl_r[CTRL_ALT_LSB +: NUM_ALT];
  assign acc_wr = avs_write_i && !avs_waitrequest_o;
  assign su_enter = usb_suspend_i && !susp_d_r;
  assign su_exit = !usb_suspend_i && susp_d_r;

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_comb begin
    sel_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case ({avs_address_i[5:2], 2'b00})
      OFS_CTRL: rd_mux = ctrl_r;
      OFS_LATCH: rd_mux = {25'h0, latch_r};
      OFS_MODE: rd_mux = {25'h0, mode_r};
      // [RULE1] pin level readback
      OFS_PIN_IN: rd_mux = {25'h0, gpio_i};
      OFS_SUSP: rd_mux = {25'h0, susp_r};
      OFS_SER: rd_mux = {20'h0, ser_pre_r, 4'h0, ser_r};
      OFS_CLKDIV: rd_mux = {24'h0, clkdiv_r};
      OFS_STATUS: rd_mux = {26'h0, chg_port_i, 1'b0, ring_indicator_input_i, su_r == SU_DYN, usb_suspend_i};
      default: sel_ok = 1'b0;
    endcase
  end

  // Readdata is latched as waitrequest drops so it is stable at the take edge
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= sel_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Control registers; only low byte lanes matter for the narrow fields
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= CTRL_RST;
      clkdiv_r <= CLKDIV_RST;
    end else if (acc_wr) begin
      if ({avs_address_i[5:2], 2'b00} == OFS_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable_i[b]) begin
            ctrl_r[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
          end
        end
      end
      if ({avs_address_i[5:2], 2'b00} == OFS_CLKDIV && avs_byteenable_i[0]) begin
        clkdiv_r <= avs_writedata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin configuration, latches and dynamic suspend
  // ----------------------------------------------------------------
  // Suspend tracking: dynamic load only from the configured state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      su_r <= SU_RUN;
      susp_d_r <= 1'b0;
    end else begin
      susp_d_r <= usb_suspend_i;
      case (su_r)
        SU_RUN: begin
          if (su_enter) begin
            su_r <= usb_configured_i ? SU_DYN : SU_HOLD;
          end
        end
        SU_HOLD, SU_DYN: begin
          if (su_exit) begin
            su_r <= SU_RUN;
          end
        end
        default: su_r <= SU_RUN;
      endcase
    end
  end

  // [RULE2] [RULE22] reset defaults, then stored configuration
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_pend_r <= 1'b1;
      latch_r <= LATCH_RST;
      mode_r <= MODE_RST;
      susp_r <= LATCH_RST;
      saved_r <= LATCH_RST;
      ser_r <= SER_RST;
      ser_pre_r <= SER_RST;
      ser_saved_r <= SER_RST;
    end else if (cfg_pend_r) begin
      // [RULE5] reset-state, suspend-state and mode from storage
      cfg_pend_r <= 1'b0;
      latch_r <= cfg_i.reset_latch;
      mode_r <= cfg_i.mode_pp;
      susp_r <= cfg_i.susp_latch;
      ser_pre_r <= cfg_i.ser_susp;
    end else if (su_r == SU_RUN && su_enter && usb_configured_i) begin
      // [RULE9] [RULE11] save and load preset per group
      saved_r <= latch_r;
      ser_saved_r <= ser_r;
      if (ctrl_r[CTRL_GPIO_DYN]) begin
        latch_r <= susp_r;
      end
      if (ctrl_r[CTRL_SER_DYN]) begin
        ser_r <= ser_pre_r;
      end
    end else if (su_r == SU_DYN && su_exit) begin
      // [RULE10] restore values held before suspend
      if (ctrl_r[CTRL_GPIO_DYN]) begin
        latch_r <= saved_r;
      end
      if (ctrl_r[CTRL_SER_DYN]) begin
        ser_r <= ser_saved_r;
      end
    end else if (acc_wr && avs_byteenable_i[0]) begin
      // [RULE1] [RULE4] software writes; [RULE8] nothing else moves latches
      case ({avs_address_i[5:2], 2'b00})
        OFS_LATCH: latch_r <= avs_writedata_i[6:0];
        OFS_MODE: mode_r <= avs_writedata_i[6:0];
        OFS_SUSP: susp_r <= avs_writedata_i[6:0];
        OFS_SER: ser_r <= avs_writedata_i[3:0];
        default: ;
      endcase
      if ({avs_address_i[5:2], 2'b00} == OFS_SER && avs_byteenable_i[1]) begin
        ser_pre_r <= avs_writedata_i[SER_PRE_LSB +: NUM_SER];
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity toggles and clock output
  // ----------------------------------------------------------------
  bpc_tick_div #(.W(32)) u_tog_div (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(1'b1),
    .limit_i(32'(TOGGLE_CYC - 1)),
    .tick_o(tog_tick)
  );

  // Divider counts N system cycles per clock half period
  bpc_tick_div #(.W(8)) u_clk_div (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(ctrl_r[CTRL_CLK_EN] && !usb_suspend_i),
    .limit_i(clkdiv_r),
    .tick_o(clk_tick)
  );

  // [RULE20] stay active one window past the last byte, rest high
  for (genvar c = 0; c < 2; c++) begin : g_tog
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        act_r[c] <= 1'b0;
        tog_r[c] <= 1'b1;
      end else begin
        if ((c == 0) ? tx_byte_i : rx_byte_i) begin
          act_r[c] <= 1'b1;
        end else if (tog_tick && tog_r[c]) begin
          act_r[c] <= 1'b0;
        end
        if (tog_tick) begin
          tog_r[c] <= act_r[c] ? !tog_r[c] : 1'b1;
        end
      end
    end
  end

  // [RULE21] clock halts low while suspended
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_out_r <= 1'b0;
    end else if (!ctrl_r[CTRL_CLK_EN] || usb_suspend_i) begin
      clk_out_r <= 1'b0;
    end else if (clk_tick) begin
      clk_out_r <= !clk_out_r;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gpio_o <= 7'h7F;
      // [RULE3] released as inputs
      gpio_oe_n_o <= 7'h7F;
      gpio_pu_o <= 7'h7F;
      ring_pin_o <= 1'b0;
      ring_pin_oe_n_o <= 1'b1;
      ser_latch_o <= SER_RST;
    end else begin
      ser_latch_o <= ser_r;
      for (int p = 0; p < NUM_PINS; p++) begin
        // [RULE12] [RULE13] push-pull drives both levels, open-drain only low
        gpio_o[p] <= latch_r[p];
        gpio_oe_n_o[p] <= !(mode_r[p] || !latch_r[p]);
        gpio_pu_o[p] <= !mode_r[p];
        if (p >= NUM_ALT && pkg != PKG_28PIN) begin
          gpio_oe_n_o[p] <= 1'b1;
          gpio_pu_o[p] <= 1'b0;
        end
      end
      // [RULE6] alternate functions by package
      if (pkg == PKG_20PIN) begin
        if (alt_en[0]) begin
          gpio_o[0] <= clk_out_r;
          gpio_oe_n_o[0] <= 1'b0;
        end
        if (alt_en[1]) begin
          gpio_o[1] <= tx_busy_i;
          gpio_oe_n_o[1] <= 1'b0;
        end
        if (alt_en[2]) begin
          gpio_o[2] <= tog_r[0];
          gpio_oe_n_o[2] <= 1'b0;
        end
        if (alt_en[3]) begin
          gpio_o[3] <= tog_r[1];
          gpio_oe_n_o[3] <= 1'b0;
        end
      end else begin
        if (alt_en[0]) begin
          gpio_o[0] <= tog_r[0];
          gpio_oe_n_o[0] <= 1'b0;
        end
        if (alt_en[1]) begin
          gpio_o[1] <= tog_r[1];
          gpio_oe_n_o[1] <= 1'b0;
        end
        if (alt_en[2]) begin
          gpio_o[2] <= tx_busy_i;
          gpio_oe_n_o[2] <= 1'b0;
        end
        if (alt_en[3]) begin
          gpio_oe_n_o[3] <= 1'b1;
          gpio_pu_o[3] <= 1'b1;
        end
      end
      // [RULE7] clock output shares the ring pin
      ring_pin_o <= clk_out_r;
      ring_pin_oe_n_o <= !(pkg != PKG_20PIN && ctrl_r[CTRL_CLK_EN]);
    end
  end

  // [RULE19] wake edge detect while suspended
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_d_r <= 1'b1;
      remote_wake_o <= 1'b0;
    end else begin
      wake_d_r <= gpio_i[3];
      remote_wake_o <= (pkg != PKG_20PIN) && alt_en[3] && usb_suspend_i && wake_d_r && !gpio_i[3];
    end
  end

  // [RULE14] [RULE15] [RULE17] charge grants from detected port
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      charge_base_enable_o <= 1'b0;
      charge_mid_current_enable_o <= 1'b0;
      charge_high_current_enable_o <= 1'b0;
    end else if (!ctrl_r[CTRL_CHG_EN] || chg_port_i == CHG_NONE || (usb_suspend_i && chg_port_i == CHG_SDP)) begin
      charge_base_enable_o <= 1'b0;
      charge_mid_current_enable_o <= 1'b0;
      charge_high_current_enable_o <= 1'b0;
    end else begin
      charge_base_enable_o <= 1'b1;
      charge_mid_current_enable_o <= chg_port_i != CHG_SDP || usb_configured_i;
      charge_high_current_enable_o <= chg_port_i != CHG_SDP;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rst_defaults_a: assert property (@(posedge sys_clk_i) $fell(sys_rst_i) |-> gpio_oe_n_o == 7'h7F && gpio_pu_o == 7'h7F) // [RULE2]
    else $error("pins not released with pull-up after reset");
  od_release_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE13]
    ##1 ($past(!mode_r[4] && latch_r[4] && pkg == PKG_28PIN)) |-> gpio_oe_n_o[4])
    else $error("open-drain pin driven with latch one");
  pp_drive_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE12]
    $past(mode_r[5] && pkg == PKG_28PIN) |-> !gpio_oe_n_o[5] && gpio_o[5] == $past(latch_r[5]))
    else $error("push-pull pin not driving latch");
  dyn_load_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || cfg_pend_r) // [RULE9]
    su_r == SU_RUN && su_enter && usb_configured_i && ctrl_r[CTRL_GPIO_DYN] |=> latch_r == $past(susp_r))
    else $error("suspend preset not loaded");
  dyn_restore_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE10]
    su_r == SU_DYN && su_exit && ctrl_r[CTRL_GPIO_DYN] |=> latch_r == $past(saved_r))
    else $error("latch not restored after suspend");
  static_susp_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE8]
    !cfg_pend_r && !ctrl_r[CTRL_GPIO_DYN] && !acc_wr |=> $stable(latch_r))
    else $error("latch moved without dynamic suspend");
  clk_stop_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE21]
    usb_suspend_i ##1 usb_suspend_i |=> !clk_out_r)
    else $error("clock output running in suspend");
  chg_sdp_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE17]
    usb_suspend_i && chg_port_i == CHG_SDP |=> !charge_base_enable_o && !charge_high_current_enable_o)
    else $error("charge pins on in suspend at data port");
  tog_idle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE20]
    !act_r[0] && tog_tick |=> tog_r[0])
    else $error("idle activity toggle not high");
  wait_one_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE1]
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low two cycles");
endmodule : bpc_top

// ---- tb/bpc_pin_model.sv ----
// Board model around the general pins: external drivers, pull-ups and floating wires
`timescale 1ns/1ps
module bpc_pin_model (
  input wire logic clk_i, // System clock
  input wire logic [6:0] drv_i, // Device drive value
  input wire logic [6:0] oe_n_i, // Device drive enable, low drives
  input wire logic [6:0] pu_i, // Device weak pull-up on
  input wire logic [6:0] ext_en_i, // Board drives the pin
  input wire logic [6:0] ext_val_i, // Board drive level
  output logic [6:0] lvl_o // Resolved pin level
);
  // A floating pin flips every cycle, so a stale level never passes for a drive
  logic [6:0] float_r = 7'h55;
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  // Device drive wins, then the board, then the pull-up, else the wire floats
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      lvl_o[k] = !oe_n_i[k] ? drv_i[k] : ext_en_i[k] ? ext_val_i[k] : pu_i[k] ? 1'b1 : float_r[k];
    end
  end
endmodule : bpc_pin_model

// ---- tb/testbench.sv ----
// Self-checking bench for the bridge pin control unit
`timescale 1ns/1ps
module testbench;
  import bpc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  bpc_cfg_s cfg_i = '{7'h00, 7'h7F, 7'h0A, 4'h5, 1'b0, 1'b0};
  logic usb_configured_i = 1'b0;
  logic usb_suspend_i = 1'b0;
  bpc_port_e chg_port_i = CHG_NONE;
  logic tx_byte_i = 1'b0;
  logic rx_byte_i = 1'b0;
  logic tx_busy_i = 1'b0;
  logic [6:0] gpio_i, gpio_o, gpio_oe_n_o, gpio_pu_o;
  logic [6:0] ext_en = 7'h00;
  logic [6:0] ext_val = 7'h00;
  logic ring_pin_o, ring_pin_oe_n_o, remote_wake_o;
  logic [3:0] ser_latch_o;
  logic [2:0] chg;
  logic [31:0] rd;
  int n_mismatch = 0;
  int cmp_count = 0;
  int c;
  // Rows: mode, latch, expected drive enables
  logic [20:0] rows [5] = '{{7'h00, 7'h00, 7'h00}, {7'h7F, 7'h55, 7'h00}, {7'h00, 7'h2A, 7'h2A},
                            {7'h0F, 7'h30, 7'h30}, {7'h00, 7'h7F, 7'h7F}};
  // Grants {1.5 A, 500 mA, 100 mA} per port type while configured
  logic [2:0] chg_tbl [4] = '{3'h0, 3'h3, 3'h7, 3'h7};
  // Ring line has a board pull-up when the device releases it
  wire logic ring_lvl = ring_pin_oe_n_o ? 1'b1 : ring_pin_o;

  always #4 sys_clk_i = ~sys_clk_i;

  bpc_top #(.TOGGLE_CYC(4)) dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .cfg_i(cfg_i), .usb_configured_i(usb_configured_i), .usb_suspend_i(usb_suspend_i), .chg_port_i(chg_port_i),
    .tx_byte_i(tx_byte_i), .rx_byte_i(rx_byte_i), .tx_busy_i(tx_busy_i), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_n_o(gpio_oe_n_o), .gpio_pu_o(gpio_pu_o), .ring_indicator_input_i(ring_lvl), .ring_pin_o(ring_pin_o),
    .ring_pin_oe_n_o(ring_pin_oe_n_o), .ser_latch_o(ser_latch_o), .charge_base_enable_o(chg[0]),
    .charge_mid_current_enable_o(chg[1]), .charge_high_current_enable_o(chg[2]), .remote_wake_o(remote_wake_o));

  bpc_pin_model pins_u (.clk_i(sys_clk_i), .drv_i(gpio_o), .oe_n_i(gpio_oe_n_o), .pu_i(gpio_pu_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(gpio_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One Avalon cycle; held until waitrequest is sampled low, released at that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) chk("bus handshake", 32'h0, 32'h1);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus

  task automatic do_reset;
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    chk("gpio_o in reset", 32'(gpio_o), 32'h7F); // latch one
    chk("gpio_oe_n in reset", 32'(gpio_oe_n_o), 32'h7F); // open drain
    chk("gpio_pu in reset", 32'(gpio_pu_o), 32'h7F); // pull-up on
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask : do_reset

  // Counts level changes of the clock-out pin over 16 cycles
  task automatic count_tog;
    logic last;
    c = 0;
    last = ring_pin_o;
    repeat (16) begin
      @(posedge sys_clk_i);
      if (ring_pin_o !== last) c++;
      last = ring_pin_o;
    end
  endtask : count_tog

  // Activity toggle on a pin: idle high, goes low after a sent byte
  task automatic tog_chk(input logic [31:0] ctrl, input int pin);
    bus(1'b1, OFS_CTRL, ctrl);
    repeat (6) @(posedge sys_clk_i);
    chk("toggle idle", 32'(gpio_i[pin]), 32'h1); // idle high
    tx_byte_i <= 1'b1;
    @(posedge sys_clk_i);
    tx_byte_i <= 1'b0;
    c = 0;
    repeat (20) begin
      @(posedge sys_clk_i);
      if (gpio_i[pin] === 1'b0) c++;
    end
    chk("toggle active", 32'(c > 0), 32'h1);
  endtask : tog_chk

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset;
    chk("inputs after reset", 32'(gpio_oe_n_o), 32'h7F);
    bus(1'b0, OFS_LATCH, 32'h0);
    chk("latch from cfg", rd, 32'h7F);
    // Table of mode and latch settings
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_MODE, 32'(rows[i][20:14]));
      bus(1'b1, OFS_LATCH, 32'(rows[i][13:7]));
      repeat (2) @(posedge sys_clk_i);
      chk("gpio_oe_n", 32'(gpio_oe_n_o), 32'(rows[i][6:0]));
      chk("push-pull drive", 32'(gpio_o & rows[i][20:14]), 32'(rows[i][13:7] & rows[i][20:14]));
      bus(1'b0, OFS_PIN_IN, 32'h0);
      chk("pin levels", rd, 32'(rows[i][13:7]));
    end
    // Static suspend, then dynamic suspend on both groups
    usb_configured_i <= 1'b1;
    bus(1'b1, OFS_LATCH, 32'h33);
    usb_suspend_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    bus(1'b0, OFS_LATCH, 32'h0);
    chk("latch static suspend", rd, 32'h33);
    usb_suspend_i <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b1, OFS_SUSP, 32'h0A);
    bus(1'b1, OFS_SER, 32'h0509);
    usb_suspend_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    bus(1'b0, OFS_LATCH, 32'h0);
    chk("latch preset", rd, 32'h0A);
    chk("serial preset", 32'(ser_latch_o), 32'h5);
    usb_suspend_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    bus(1'b0, OFS_LATCH, 32'h0);
    chk("latch restored", rd, 32'h33);
    chk("serial restored", 32'(ser_latch_o), 32'h9);
    // Charge grants per port type, awake and suspended
    bus(1'b1, OFS_CTRL, 32'h4);
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        chg_port_i <= bpc_port_e'(p[1:0]);
        usb_suspend_i <= s[0];
        repeat (3) @(posedge sys_clk_i);
        chk("charge grants", 32'(chg), (s == 1 && p == 1) ? 32'h0 : 32'(chg_tbl[p]));
      end
    end
    usb_suspend_i <= 1'b0;
    // Clock out on the ring pin, N of two, stopped in suspend
    bus(1'b1, OFS_CLKDIV, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h8);
    repeat (4) @(posedge sys_clk_i);
    chk("ring pin driven", 32'(ring_pin_oe_n_o), 32'h0);
    count_tog;
    chk("clock out edges", 32'(c), 32'h8);
    usb_suspend_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    count_tog;
    chk("clock stopped", 32'(c), 32'h0);
    usb_suspend_i <= 1'b0;
    // Activity toggles on the large and the small package
    tog_chk(32'h100, 0);
    tog_chk(32'h420, 2);
    // Wake input pulled low during suspend gives one pulse
    bus(1'b1, OFS_CTRL, 32'h800);
    usb_suspend_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    ext_en <= 7'h08;
    c = 0;
    repeat (8) begin
      @(posedge sys_clk_i);
      if (remote_wake_o === 1'b1) c++;
    end
    chk("wake pulses", 32'(c), 32'h1);
    ext_en <= 7'h00;
    usb_suspend_i <= 1'b0;
    // Unmapped place reads zero and ignores writes
    bus(1'b1, 6'h20, 32'hFFFF_FFFF);
    bus(1'b0, 6'h20, 32'h0);
    chk("unmapped read", rd, 32'h0);
    // Second reset with a different stored configuration
    cfg_i <= '{7'h0F, 7'h12, 7'h0A, 4'h5, 1'b0, 1'b0};
    do_reset;
    bus(1'b0, OFS_LATCH, 32'h0);
    chk("reset latch", rd, 32'h12);
    bus(1'b0, OFS_MODE, 32'h0);
    chk("reset mode", rd, 32'h0F);
    report_and_stop;
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    report_and_stop;
  end
endmodule : testbench
